// ---- pkg/mdc_defs.svh ----
// constants of the sixteen-channel downconverter
// assumes inclusion by bare name from the package and the modules
// Behaviour
// - sixteen independent channels share one time-multiplexed datapath.
// - each channel is mixed with its own oscillator, then decimated by sixteen in an integrator-comb filter.
// - two symmetric FIR decimators by four follow, with 21 and 63 taps.
// - rounding and saturation sit between stages, and each stage has a run-time gain shift.
// - coefficients, gains and oscillator steps sit behind one decoded register port with a read mux.
// - the register port has an 8-bit address and 32-bit data.
// - the register port runs on its own bus clock, which may be slower than the system clock.
// - the input sample rate is a quarter of the system clock, so four channel slots share one wire.
// - results leave as a stream of data word, valid flag and channel index.
// - the valid flag marks each cycle whose data word is a real result.
// - while valid is high the channel index names the channel of the data word.
// - the integrator-comb filter has five stages and a differential delay of one.
// - the integrator-comb output comes in bursts of sixteen contiguous samples, channels 0 to 15.
// - FIR coefficients are signed 16-bit with 15 fraction bits.
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
`define MDC_CHANS      16
`define MDC_SLOTS      4
`define MDC_CIC_DECIM  16
`define MDC_CIC_STAGES 5
`define MDC_CIC_SHIFT  20
`define MDC_FIR1_TAPS  21
`define MDC_FIR2_TAPS  63
`define MDC_FIR_DECIM  4
`define MDC_COEF_FRAC  15
`define MDC_ADDR_NCO   8'h00
`define MDC_ADDR_GAIN  8'h10
`define MDC_ADDR_FIR1  8'h20
`define MDC_FIR1_END   8'h35
`define MDC_ADDR_FIR2  8'h40
`define MDC_FIR2_END   8'h7F
`define MDC_GAIN_RST   32'h0000_0000
`define MDC_GAIN_MASK  32'h0000_0777
`define MDC_GAIN_CIC   2:0
`define MDC_GAIN_FIR1  6:4
`define MDC_GAIN_FIR2  10:8
`endif

// ---- pkg/mdc_pkg.sv ----
// types and helpers of the downconverter
// assumes the constants header on the include path
`include "mdc_defs.svh"
package mdc_pkg;
	typedef logic signed [15:0] mdc_smp_t;
	typedef enum logic [0:0] {MDC_IDLE = 1'b0, MDC_RUN = 1'b1} mdc_fir_st_t;
	typedef enum logic [2:0] {
		MDC_SEL_NONE = 3'b000,
		MDC_SEL_NCO  = 3'b001,
		MDC_SEL_GAIN = 3'b010,
		MDC_SEL_FIR1 = 3'b011,
		MDC_SEL_FIR2 = 3'b100
	} mdc_sel_t;

	function automatic mdc_sel_t mdc_reg_sel(input logic [7:0] a);
		if (a < `MDC_ADDR_GAIN) return MDC_SEL_NCO;
		if (a == `MDC_ADDR_GAIN) return MDC_SEL_GAIN;
		if (a >= `MDC_ADDR_FIR1 && a < `MDC_FIR1_END) return MDC_SEL_FIR1;
		if (a >= `MDC_ADDR_FIR2 && a < `MDC_FIR2_END) return MDC_SEL_FIR2;
		return MDC_SEL_NONE;
	endfunction

	// round half up, shift right, clamp to 16 bits
	function automatic mdc_smp_t mdc_round_sat(input logic signed [47:0] v, input logic [5:0] sh);
		logic signed [47:0] r;
		r = (sh == 6'h00) ? v : ((v + (48'sh0000_0000_0001 <<< (sh - 6'h01))) >>> sh);
		if (r > 48'sh0000_0000_7FFF) return 16'sh7FFF;
		if (r < -48'sh0000_0000_8000) return -16'sh8000;
		return mdc_smp_t'(r[15:0]);
	endfunction
endpackage

// ---- pkg/mdc_stream_if.sv ----
// time-multiplexed sample stream between stages
// assumes one producer and one consumer on clk_sys
`timescale 1ns/1ps
interface mdc_stream_if;
	logic [31:0] data;
	logic        valid;
	logic [3:0]  chan;
	modport src (output data, output valid, output chan);
	modport snk (input data, input valid, input chan);
endinterface

// ---- rtl/mdc_cic_lane.sv ----
// one real lane: mixer product and five-stage integrator-comb for four slots
// assumes slot-tagged samples and a shared dump strobe from the top
`timescale 1ns/1ps
`include "mdc_defs.svh"
module mdc_cic_lane (
	input  wire logic                   clk_sys,
	input  wire logic                   resetn,
	input  wire logic                   smpValid,
	input  wire logic [1:0]             smpSlot,
	input  wire logic signed [13:0]     smpIn,
	input  wire logic signed [11:0]     osc,
	input  wire logic                   dump,
	input  wire logic [2:0]             gainSh,
	output logic                        outValid,
	output logic [1:0]                  outSlot,
	output mdc_pkg::mdc_smp_t           outData
);
	logic signed [35:0] integQ [4][5];
	logic signed [35:0] integD [4][5];
	logic signed [35:0] combQ  [4][5];
	logic signed [35:0] combD  [4][5];
	logic               oValidQ, oValidD;
	logic [1:0]         oSlotQ, oSlotD;
	mdc_pkg::mdc_smp_t  oDataQ, oDataD;
	logic signed [25:0] prod;
	logic signed [35:0] acc, c, t;

	// ==========================================
	// mixer and filter
	always_comb begin
		integD  = integQ;
		combD   = combQ;
		oValidD = 1'b0;
		oSlotD  = oSlotQ;
		oDataD  = oDataQ;
		prod    = smpIn * osc;
		// part-select is unsigned, so the sign is restored before widening
		acc     = 36'($signed(prod[25:10]));
		c       = '0;
		t       = '0;
		if (smpValid) begin
			for (int k = 0; k < `MDC_CIC_STAGES; k++) begin
				acc = integQ[smpSlot][k] + acc;
				integD[smpSlot][k] = acc;
			end
			if (dump) begin
				c = acc;
				for (int k = 0; k < `MDC_CIC_STAGES; k++) begin
					t = c - combQ[smpSlot][k];
					combD[smpSlot][k] = c;
					c = t;
				end
				oValidD = 1'b1;
				oSlotD  = smpSlot;
				// gain 2^20 removed here, less the run-time shift
				oDataD  = mdc_pkg::mdc_round_sat(48'(c), 6'(`MDC_CIC_SHIFT) - {3'b000, gainSh});
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			integQ  <= '{default: '0};
			combQ   <= '{default: '0};
			oValidQ <= 1'b0;
			oSlotQ  <= 2'h0;
			oDataQ  <= 16'h0000;
		end else begin
			integQ  <= integD;
			combQ   <= combD;
			oValidQ <= oValidD;
			oSlotQ  <= oSlotD;
			oDataQ  <= oDataD;
		end
	end

	assign outValid = oValidQ;
	assign outSlot  = oSlotQ;
	assign outData  = oDataQ;

	a_cic_dump_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		outValid |-> $past(smpValid && dump) && outSlot == $past(smpSlot))
		else $error("lane result without a dump sample");
endmodule // mdc_cic_lane

// ---- rtl/mdc_downconverter_top.sv ----
// sixteen-channel downconverter: oscillators, mixers, integrator-comb, two FIR stages, host registers
// assumes inputs synchronous to clk_sys and a host port on its own bus clock
`timescale 1ns/1ps
`include "mdc_defs.svh"
module mdc_downconverter_top (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [13:0] mainAntennaSample,
	input  wire logic [13:0] diversityAntennaSample,
	input  wire logic [1:0]  inputChannelTag,
	input  wire logic        inputSampleValid,
	input  wire logic        busClk,
	input  wire logic [7:0]  busAddr,
	input  wire logic [31:0] busWrData,
	input  wire logic        busWrEn,
	output logic             busWrReady,
	input  wire logic        busRdEn,
	output logic [31:0]      busRdData,
	output logic             busRdValid,
	output logic [31:0]      outData,
	output logic             outValid,
	output logic [3:0]       outChan
);
	// ==========================================
	// bus domain: shadow copies for read-back, write launch
	logic [31:0] ncoBusQ [`MDC_CHANS];
	logic [31:0] ncoBusD [`MDC_CHANS];
	logic [15:0] f1BusQ  [`MDC_FIR1_TAPS];
	logic [15:0] f1BusD  [`MDC_FIR1_TAPS];
	logic [15:0] f2BusQ  [`MDC_FIR2_TAPS];
	logic [15:0] f2BusD  [`MDC_FIR2_TAPS];
	logic [31:0] gainBusQ, gainBusD;
	logic [7:0]  holdAddrQ, holdAddrD;
	logic [31:0] holdDataQ, holdDataD;
	logic        reqTogQ, reqTogD;
	logic        ackS1Q, ackS2Q;
	logic        reqS1Q, reqS2Q, reqSeenQ, apply;
	logic [31:0] rdDataQ, rdDataD;
	logic        rdValidQ;
	logic [4:0]  f1Idx;
	logic [5:0]  f2Idx;

	assign busWrReady = (reqTogQ == ackS2Q);
	assign f1Idx      = 5'(busAddr - `MDC_ADDR_FIR1);
	assign f2Idx      = 6'(busAddr - `MDC_ADDR_FIR2);

	always_comb begin
		ncoBusD   = ncoBusQ;
		f1BusD    = f1BusQ;
		f2BusD    = f2BusQ;
		gainBusD  = gainBusQ;
		holdAddrD = holdAddrQ;
		holdDataD = holdDataQ;
		reqTogD   = reqTogQ;
		rdDataD   = rdDataQ;
		if (busWrEn && busWrReady) begin
			holdAddrD = busAddr;
			holdDataD = busWrData;
			reqTogD   = !reqTogQ;
			unique case (mdc_pkg::mdc_reg_sel(busAddr))
				mdc_pkg::MDC_SEL_NCO:  ncoBusD[busAddr[3:0]] = busWrData;
				mdc_pkg::MDC_SEL_GAIN: gainBusD = busWrData & `MDC_GAIN_MASK;
				mdc_pkg::MDC_SEL_FIR1: f1BusD[f1Idx] = busWrData[15:0];
				mdc_pkg::MDC_SEL_FIR2: f2BusD[f2Idx] = busWrData[15:0];
				mdc_pkg::MDC_SEL_NONE: ;
			endcase
		end
		if (busRdEn) begin
			unique case (mdc_pkg::mdc_reg_sel(busAddr))
				mdc_pkg::MDC_SEL_NCO:  rdDataD = ncoBusQ[busAddr[3:0]];
				mdc_pkg::MDC_SEL_GAIN: rdDataD = gainBusQ;
				mdc_pkg::MDC_SEL_FIR1: rdDataD = {{16{f1BusQ[f1Idx][15]}}, f1BusQ[f1Idx]};
				mdc_pkg::MDC_SEL_FIR2: rdDataD = {{16{f2BusQ[f2Idx][15]}}, f2BusQ[f2Idx]};
				mdc_pkg::MDC_SEL_NONE: rdDataD = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge busClk or negedge resetn) begin
		if (!resetn) begin
			ncoBusQ   <= '{default: 32'h0000_0000};
			f1BusQ    <= '{default: 16'h0000};
			f2BusQ    <= '{default: 16'h0000};
			gainBusQ  <= `MDC_GAIN_RST;
			holdAddrQ <= 8'h00;
			holdDataQ <= 32'h0000_0000;
			reqTogQ   <= 1'b0;
			ackS1Q    <= 1'b0;
			ackS2Q    <= 1'b0;
			rdDataQ   <= 32'h0000_0000;
			rdValidQ  <= 1'b0;
		end else begin
			ncoBusQ   <= ncoBusD;
			f1BusQ    <= f1BusD;
			f2BusQ    <= f2BusD;
			gainBusQ  <= gainBusD;
			holdAddrQ <= holdAddrD;
			holdDataQ <= holdDataD;
			reqTogQ   <= reqTogD;
			ackS1Q    <= reqSeenQ;
			ackS2Q    <= ackS1Q;
			rdDataQ   <= rdDataD;
			rdValidQ  <= busRdEn;
		end
	end

	assign busRdData  = rdDataQ;
	assign busRdValid = rdValidQ;

	// ==========================================
	// system domain: working copies, updated by toggle handshake
	// hold registers stay frozen until the ack returns, so sampling them here is safe
	logic [31:0] ncoStepQ [`MDC_CHANS];
	logic [31:0] ncoStepD [`MDC_CHANS];
	logic [15:0] f1Q      [`MDC_FIR1_TAPS];
	logic [15:0] f1D      [`MDC_FIR1_TAPS];
	logic [15:0] f2Q      [`MDC_FIR2_TAPS];
	logic [15:0] f2D      [`MDC_FIR2_TAPS];
	logic [31:0] gainQ, gainD;

	assign apply = (reqS2Q != reqSeenQ);

	always_comb begin
		ncoStepD = ncoStepQ;
		f1D      = f1Q;
		f2D      = f2Q;
		gainD    = gainQ;
		if (apply) begin
			unique case (mdc_pkg::mdc_reg_sel(holdAddrQ))
				mdc_pkg::MDC_SEL_NCO:  ncoStepD[holdAddrQ[3:0]] = holdDataQ;
				mdc_pkg::MDC_SEL_GAIN: gainD = holdDataQ & `MDC_GAIN_MASK;
				mdc_pkg::MDC_SEL_FIR1: f1D[5'(holdAddrQ - `MDC_ADDR_FIR1)] = holdDataQ[15:0];
				mdc_pkg::MDC_SEL_FIR2: f2D[6'(holdAddrQ - `MDC_ADDR_FIR2)] = holdDataQ[15:0];
				mdc_pkg::MDC_SEL_NONE: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ncoStepQ <= '{default: 32'h0000_0000};
			f1Q      <= '{default: 16'h0000};
			f2Q      <= '{default: 16'h0000};
			gainQ    <= `MDC_GAIN_RST;
			reqS1Q   <= 1'b0;
			reqS2Q   <= 1'b0;
			reqSeenQ <= 1'b0;
		end else begin
			ncoStepQ <= ncoStepD;
			f1Q      <= f1D;
			f2Q      <= f2D;
			gainQ    <= gainD;
			reqS1Q   <= reqTogQ;
			reqS2Q   <= reqS1Q;
			reqSeenQ <= reqS2Q;
		end
	end

	// ==========================================
	// oscillators and decimation frame counter
	// coarse 64-point wave; spurs near -36 dBc traded for a tiny table
	function automatic logic signed [11:0] sinLut(input logic [5:0] p);
		logic [3:0]  i;
		logic [11:0] m;
		i = p[4] ? ~p[3:0] : p[3:0];
		unique case (i)
			4'h0: m = 12'h000; 4'h1: m = 12'h0C9; 4'h2: m = 12'h18F; 4'h3: m = 12'h252;
			4'h4: m = 12'h30F; 4'h5: m = 12'h3C5; 4'h6: m = 12'h471; 4'h7: m = 12'h512;
			4'h8: m = 12'h5A7; 4'h9: m = 12'h62E; 4'hA: m = 12'h6A6; 4'hB: m = 12'h70D;
			4'hC: m = 12'h763; 4'hD: m = 12'h7A7; 4'hE: m = 12'h7D8; 4'hF: m = 12'h7F5;
		endcase
		return p[5] ? -$signed(m) : $signed(m);
	endfunction

	logic [31:0] phaseQ [`MDC_CHANS];
	logic [31:0] phaseD [`MDC_CHANS];
	logic [3:0]  decCntQ, decCntD;
	logic        dump;

	assign dump = (decCntQ == 4'(`MDC_CIC_DECIM - 1));

	always_comb begin
		phaseD  = phaseQ;
		decCntD = decCntQ;
		if (inputSampleValid) begin
			for (int j = 0; j < `MDC_SLOTS; j++)
				phaseD[{inputChannelTag, 2'(j)}] = phaseQ[{inputChannelTag, 2'(j)}]
					+ ncoStepQ[{inputChannelTag, 2'(j)}];
			if (inputChannelTag == 2'(`MDC_SLOTS - 1))
				decCntD = decCntQ + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phaseQ  <= '{default: 32'h0000_0000};
			decCntQ <= 4'h0;
		end else begin
			phaseQ  <= phaseD;
			decCntQ <= decCntD;
		end
	end

	// ==========================================
	// eight lanes: antenna x oscillator pair x in-phase/quadrature
	logic              laneValid [8];
	logic [1:0]        laneSlot  [8];
	mdc_pkg::mdc_smp_t laneData  [8];

	for (genvar l = 0; l < 8; l++) begin : gLane
		logic [31:0]        ph;
		logic signed [11:0] osc;
		assign ph  = phaseQ[{inputChannelTag, 2'(l / 2)}];
		// even lanes use the cosine, odd lanes the sine
		assign osc = sinLut(ph[31:26] + ((l % 2 == 0) ? 6'h10 : 6'h00));
		mdc_cic_lane uLane (
			.clk_sys  (clk_sys),
			.resetn   (resetn),
			.smpValid (inputSampleValid),
			.smpSlot  (inputChannelTag),
			.smpIn    ((l / 4 == 0) ? $signed(mainAntennaSample) : $signed(diversityAntennaSample)),
			.osc      (osc),
			.dump     (dump),
			.gainSh   (gainQ[`MDC_GAIN_CIC]),
			.outValid (laneValid[l]),
			.outSlot  (laneSlot[l]),
			.outData  (laneData[l])
		);
	end

	// ==========================================
	// capture and burst emitter, channels 0..15 back to back
	logic [31:0] capQ [`MDC_CHANS];
	logic [31:0] capD [`MDC_CHANS];
	logic        burstOnQ, burstOnD;
	logic [3:0]  cntQ, cntD;
	logic [31:0] cicDataQ, cicDataD;
	logic        cicValidQ, cicValidD;
	logic [3:0]  cicChanQ, cicChanD;

	always_comb begin
		capD      = capQ;
		burstOnD  = burstOnQ;
		cntD      = cntQ;
		cicValidD = 1'b0;
		cicDataD  = cicDataQ;
		cicChanD  = cicChanQ;
		for (int l = 0; l < 8; l++) begin
			if (laneValid[l]) begin
				if (l % 2 == 0)
					capD[{laneSlot[l], 2'(l / 2)}][31:16] = laneData[l];
				else
					capD[{laneSlot[l], 2'(l / 2)}][15:0] = laneData[l];
			end
		end
		if (burstOnQ) begin
			cicValidD = 1'b1;
			cicChanD  = cntQ;
			cicDataD  = capQ[cntQ];
			cntD      = cntQ + 4'h1;
			if (cntQ == 4'(`MDC_CHANS - 1))
				burstOnD = 1'b0;
		end else if (laneValid[0] && laneSlot[0] == 2'(`MDC_SLOTS - 1)) begin
			burstOnD = 1'b1;
			cntD     = 4'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			capQ      <= '{default: 32'h0000_0000};
			burstOnQ  <= 1'b0;
			cntQ      <= 4'h0;
			cicValidQ <= 1'b0;
			cicDataQ  <= 32'h0000_0000;
			cicChanQ  <= 4'h0;
		end else begin
			capQ      <= capD;
			burstOnQ  <= burstOnD;
			cntQ      <= cntD;
			cicValidQ <= cicValidD;
			cicDataQ  <= cicDataD;
			cicChanQ  <= cicChanD;
		end
	end

	// ==========================================
	// FIR stages and output stream
	mdc_stream_if cicS ();
	mdc_stream_if f1S ();
	mdc_stream_if f2S ();

	assign cicS.data  = cicDataQ;
	assign cicS.valid = cicValidQ;
	assign cicS.chan  = cicChanQ;

	mdc_fir #(.TAPS(`MDC_FIR1_TAPS), .CHANS(`MDC_CHANS), .DECIM(`MDC_FIR_DECIM)) uFir1 (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.coef    (f1Q),
		.gainSh  (gainQ[`MDC_GAIN_FIR1]),
		.inS     (cicS),
		.outS    (f1S)
	);

	mdc_fir #(.TAPS(`MDC_FIR2_TAPS), .CHANS(`MDC_CHANS), .DECIM(`MDC_FIR_DECIM)) uFir2 (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.coef    (f2Q),
		.gainSh  (gainQ[`MDC_GAIN_FIR2]),
		.inS     (f1S),
		.outS    (f2S)
	);

	assign outData  = f2S.data;
	assign outValid = f2S.valid;
	assign outChan  = f2S.chan;

	// ==========================================
	// checks
	a_burst_run: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(cicValidQ) |-> cicChanQ == 4'h0) and (cicValidQ && cicChanQ == 4'hF |=> !cicValidQ))
		else $error("integrator-comb burst not sixteen long");
	a_burst_order: assert property (@(posedge clk_sys) disable iff (!resetn)
		cicValidQ && cicChanQ != 4'hF |=> cicValidQ && cicChanQ == $past(cicChanQ) + 4'h1)
		else $error("burst channels out of order");
	a_dump_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
		inputSampleValid && inputChannelTag == 2'h3 |=> decCntQ == $past(decCntQ) + 4'h1)
		else $error("frame counter missed a slot-three sample");
	a_gain_cross: assert property (@(posedge clk_sys) disable iff (!resetn)
		apply && mdc_pkg::mdc_reg_sel(holdAddrQ) == mdc_pkg::MDC_SEL_GAIN
		|=> gainQ == ($past(holdDataQ) & `MDC_GAIN_MASK) && !apply)
		else $error("gain write not applied once");
	a_host_busy: assert property (@(posedge busClk) disable iff (!resetn)
		busWrEn && busWrReady |=> !busWrReady)
		else $error("write port ready while a write is in flight");
	a_rd_gain: assert property (@(posedge busClk) disable iff (!resetn)
		busRdEn && busAddr == `MDC_ADDR_GAIN |=> busRdValid && busRdData == $past(gainBusQ))
		else $error("gain read-back mismatch");
endmodule // mdc_downconverter_top

// ---- rtl/mdc_fir.sv ----
// decimate-by-four symmetric FIR, one pair of taps per cycle, all channels in turn
// assumes input bursts with channels 0..15 and compute time below the decimated period
`timescale 1ns/1ps
`include "mdc_defs.svh"
module mdc_fir #(
	parameter int TAPS  = 21,
	parameter int CHANS = 16,
	parameter int DECIM = 4
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [15:0] coef [TAPS],
	input  wire logic [2:0]  gainSh,
	mdc_stream_if.snk        inS,
	mdc_stream_if.src        outS
);
	localparam int NP = (TAPS + 1) / 2;
	localparam int AW = $clog2(TAPS + DECIM);
	localparam int KW = $clog2(NP + 1);
	localparam int PW = $clog2(DECIM);
	// ring deeper than the taps so new bursts land outside the window in use
	logic [31:0]              hist [CHANS][2**AW];
	logic [AW-1:0]            wrQ, wrD, baseQ, baseD;
	logic [PW-1:0]            phQ, phD;
	mdc_pkg::mdc_fir_st_t     stQ, stD;
	logic [3:0]               chQ, chD;
	logic [KW-1:0]            kQ, kD;
	logic signed [39:0]       accIQ, accID, accQQ, accQD, nI, nQ;
	logic [31:0]              oDataQ, oDataD, tapA, tapB;
	logic                     oValidQ, oValidD, lastBurst;
	logic [3:0]               oChanQ, oChanD;
	logic signed [16:0]       sumI, sumQ;

	assign lastBurst = inS.valid && inS.chan == 4'(CHANS - 1);

	// ==========================================
	// sequencer and multiply-accumulate
	always_comb begin
		wrD     = wrQ;
		phD     = phQ;
		baseD   = baseQ;
		stD     = stQ;
		chD     = chQ;
		kD      = kQ;
		accID   = accIQ;
		accQD   = accQQ;
		oValidD = 1'b0;
		oDataD  = oDataQ;
		oChanD  = oChanQ;
		tapA    = hist[chQ][baseQ - AW'(kQ)];
		tapB    = (kQ == KW'(NP - 1)) ? 32'h0000_0000 : hist[chQ][baseQ - AW'(TAPS - 1) + AW'(kQ)];
		sumI    = $signed({tapA[31], tapA[31:16]}) + $signed({tapB[31], tapB[31:16]});
		sumQ    = $signed({tapA[15], tapA[15:0]}) + $signed({tapB[15], tapB[15:0]});
		nI      = accIQ + 40'($signed(coef[kQ]) * sumI);
		nQ      = accQQ + 40'($signed(coef[kQ]) * sumQ);
		if (lastBurst) begin
			wrD = wrQ + 1'b1;
			phD = (phQ == PW'(DECIM - 1)) ? '0 : phQ + 1'b1;
		end
		unique case (stQ)
			mdc_pkg::MDC_IDLE: begin
				if (lastBurst && phQ == PW'(DECIM - 1)) begin
					stD   = mdc_pkg::MDC_RUN;
					baseD = wrQ;
					chD   = 4'h0;
					kD    = '0;
					accID = '0;
					accQD = '0;
				end
			end
			mdc_pkg::MDC_RUN: begin
				accID = nI;
				accQD = nQ;
				kD    = kQ + 1'b1;
				if (kQ == KW'(NP - 1)) begin
					oValidD = 1'b1;
					oChanD  = chQ;
					oDataD  = {mdc_pkg::mdc_round_sat(48'(nI), 6'(`MDC_COEF_FRAC) - {3'b000, gainSh}),
						mdc_pkg::mdc_round_sat(48'(nQ), 6'(`MDC_COEF_FRAC) - {3'b000, gainSh})};
					accID   = '0;
					accQD   = '0;
					kD      = '0;
					chD     = chQ + 1'b1;
					if (chQ == 4'(CHANS - 1))
						stD = mdc_pkg::MDC_IDLE;
				end
			end
		endcase
	end

	// zeroed at reset so the first rounds start from silence, not stale words
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			hist <= '{default: 32'h0000_0000};
		else if (inS.valid)
			hist[inS.chan][wrQ] <= inS.data;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wrQ <= '0; phQ <= '0; baseQ <= '0; stQ <= mdc_pkg::MDC_IDLE;
			chQ <= 4'h0; kQ <= '0; accIQ <= '0; accQQ <= '0;
			oValidQ <= 1'b0; oDataQ <= 32'h0000_0000; oChanQ <= 4'h0;
		end else begin
			wrQ <= wrD; phQ <= phD; baseQ <= baseD; stQ <= stD;
			chQ <= chD; kQ <= kD; accIQ <= accID; accQQ <= accQD;
			oValidQ <= oValidD; oDataQ <= oDataD; oChanQ <= oChanD;
		end
	end

	assign outS.valid = oValidQ;
	assign outS.data  = oDataQ;
	assign outS.chan  = oChanQ;

	a_fir_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
		oValidQ && oChanQ != 4'(CHANS - 1) |-> ##NP (oValidQ && oChanQ == $past(oChanQ, NP) + 4'h1))
		else $error("fir results not spaced by the pair count");
	a_fir_decim: assert property (@(posedge clk_sys) disable iff (!resetn)
		stQ == mdc_pkg::MDC_RUN && $past(stQ) == mdc_pkg::MDC_IDLE |-> $past(phQ) == PW'(DECIM - 1))
		else $error("fir started off the decimation phase");
endmodule // mdc_fir

// ---- tb/mdc_adc_model.sv ----
// converter source: slot-tagged sample pairs
// assumes free-running clk_sys; run gates the stream
`timescale 1ns/1ps
module mdc_adc_model (
	input  wire logic   clk_sys,
	input  wire logic   resetn,
	input  wire logic   run,
	output logic [13:0] mainS,
	output logic [13:0] divS,
	output logic [1:0]  tag,
	output logic        valid
);
	// ====================
	// source
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			{mainS, divS, tag, valid} <= '0;
		end else if (run) begin
			mainS <= 14'h0FFF;
			divS  <= 14'h3000;
			tag   <= valid ? tag + 2'h1 : 2'h0;
			valid <= 1'b1;
		end else begin
			// idle lines toggle, never a stale sample
			mainS <= ~mainS;
			divS  <= ~divS;
			valid <= 1'b0;
		end
	end
endmodule // mdc_adc_model

// ---- tb/testbench.sv ----
// bench for the downconverter: host port and output stream
// assumes the adc model beside it
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, resetn, busClk, run, busWrEn, busWrReady, busRdEn, busRdValid, outValid, inV;
	logic [13:0] mS, dS;
	logic [1:0]  tag;
	logic [7:0]  busAddr;
	logic [31:0] busWrData, busRdData, outData;
	logic [3:0]  outChan;
	int          num_errors, samples_checked, cycles;
	mdc_downconverter_top uut (.clk_sys(clk_sys), .resetn(resetn), .mainAntennaSample(mS),
		.diversityAntennaSample(dS), .inputChannelTag(tag), .inputSampleValid(inV), .busClk(busClk),
		.busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn), .busWrReady(busWrReady),
		.busRdEn(busRdEn), .busRdData(busRdData), .busRdValid(busRdValid), .outData(outData),
		.outValid(outValid), .outChan(outChan));
	mdc_adc_model adc (.clk_sys(clk_sys), .resetn(resetn), .run(run), .mainS(mS), .divS(dS),
		.tag(tag), .valid(inV));
	// ====================
	// clocks
	initial begin clk_sys = 1'b0; forever #25 clk_sys = ~clk_sys; end
	initial begin busClk = 1'b0; #7; forever #20 busClk = ~busClk; end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin num_errors++; final_report(); end
	end
	// ====================
	// helpers
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin num_errors++; $display("[FAIL] %s exp %h seen %h", n, e, s); end
	endtask
	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		do begin @(posedge busClk); n++; end while (busWrReady !== 1'b1 && n < 60);
		check("wrReady", {31'h0, busWrReady}, 32'h0000_0001);
		busAddr <= a; busWrData <= d; busWrEn <= 1'b1;
		@(posedge busClk); busWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge busClk); busAddr <= a; busRdEn <= 1'b1;
		@(posedge busClk); busRdEn <= 1'b0;
		#1 check("rdValid", {31'h0, busRdValid}, 32'h0000_0001);
		check("rdData", busRdData, e);
	endtask
	// ====================
	// scenarios
	task automatic t_reset();
		check("outValid", {31'h0, outValid}, 32'h0000_0000);
		check("wrReady", {31'h0, busWrReady}, 32'h0000_0001);
	endtask
	task automatic t_regs();
		wr(8'h10, 32'hFFFF_FFFF); rd(8'h10, 32'h0000_0777);
		wr(8'h20, 32'h0000_8000); rd(8'h20, 32'hFFFF_8000);
		wr(8'h00, 32'h1234_5678); rd(8'h00, 32'h1234_5678);
		wr(8'h00, 32'h0000_0000); rd(8'h00, 32'h0000_0000);
		wr(8'h5F, 32'h0000_4000); rd(8'h5F, 32'h0000_4000);
		wr(8'h7F, 32'hFFFF_FFFF); rd(8'h7F, 32'h0000_0000);
		rd(8'h80, 32'h0000_0000);
	endtask
	task automatic t_stream();
		int gap;
		int rounds;
		run <= 1'b1;
		gap = 0;
		rounds = 0;
		// early rounds still reach back into the zeroed filter history
		while (rounds < 12 && gap < 20000) begin
			@(posedge clk_sys); #1; gap++;
			if (outValid === 1'b1 && outChan === 4'hF) rounds++;
		end
		// all stages saturate: main antenna in-phase at full negative, diversity full positive
		for (int c = 0; c < 16; c++) begin
			gap = 0;
			do begin @(posedge clk_sys); #1; gap++; end while (outValid !== 1'b1 && gap < 1100);
			if (c > 0) check("gap", gap, 32'h0000_0020);
			check("valid", {31'h0, outValid}, 32'h0000_0001);
			check("chan", {28'h0, outChan}, c);
			check("data", outData, c[1] ? 32'h7FFF_0000 : 32'h8000_0000);
		end
	endtask
	// ====================
	// main
	initial begin
		{resetn, run, busWrEn, busRdEn, busAddr, busWrData} = '0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys); #1;
		t_reset();
		t_regs();
		t_stream();
		final_report();
	end
endmodule // testbench
